/* pkg/rre_pkg.sv */
// package: constants and carrier types for the return / rotate execution block
package rre_pkg;

   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int DATA_W  = 8;
   localparam int PC_W    = 21;
   localparam int INSN_W  = 16;
   localparam int BANK_W  = 4;
   localparam int FADDR_W = 12;
   localparam int STK_W   = 5;

   // ----------------------------------------
   // opcode patterns
   // ----------------------------------------
   localparam logic [14:0] OPC_RETURN_HI = 15'h0009;  // 0000 0000 0001 001 (top 15 bits)
   localparam logic [5:0]  OPC_ROTATE_LEFT_CARRY_OP_HI   = 6'h0D;     // 0011 01
   localparam int          RET_S_BIT     = 0;
   localparam int          ROT_A_BIT     = 8;
   localparam int          ROT_D_BIT     = 9;

   // ----------------------------------------
   // flag register layout
   // ----------------------------------------
   localparam int FLG_C = 0;
   localparam int FLG_Z = 2;
   localparam int FLG_N = 4;

   // access bank: low half in bank 0, high half in the top bank
   localparam logic [7:0]        ACC_SPLIT = 8'h80;
   localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hF;
   localparam logic [BANK_W-1:0] ACC_LO_BANK = 4'h0;

   // ----------------------------------------
   // register bus map (word offsets x4)
   // ----------------------------------------
   localparam logic [3:0] ADR_INSN   = 4'h0;  // write: execute opcode
   localparam logic [3:0] ADR_PC     = 4'h1;
   localparam logic [3:0] ADR_WORK   = 4'h2;
   localparam logic [3:0] ADR_FLAGS  = 4'h3;
   localparam logic [3:0] ADR_BANK   = 4'h4;
   localparam logic [3:0] ADR_SHW    = 4'h5;
   localparam logic [3:0] ADR_SHF    = 4'h6;
   localparam logic [3:0] ADR_SHB    = 4'h7;
   localparam logic [3:0] ADR_PUSH   = 4'h8;  // write: push value onto return stack
   localparam logic [3:0] ADR_FADDR  = 4'h9;  // file address for direct access
   localparam logic [3:0] ADR_FDATA  = 4'hA;  // file data at FADDR
   localparam logic [3:0] ADR_STAT   = 4'hB;  // stack depth, under/overflow
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

   typedef enum logic [1:0] {RRE_IDLE, RRE_READ, RRE_RESP} rre_state_type;

   typedef struct packed {
      logic [DATA_W-1:0] work;
      logic [DATA_W-1:0] flags;
      logic [BANK_W-1:0] bank;
   } rre_ctx_type;

endpackage

/* rtl/rre_stack.sv */
// hardware return stack with push and pop
module rre_stack
   import rre_pkg::*;
#(
   parameter int DEPTH = 31
) (
   input  wire logic            i_clk,
   input  wire logic            i_arst_n,
   input  wire logic            i_ce,
   input  wire logic            i_push,
   input  wire logic            i_pop,
   input  wire logic [PC_W-1:0] i_data,
   output logic [PC_W-1:0]      o_top,
   output logic [STK_W-1:0]     o_depth,
   output logic                 o_under,
   output logic                 o_over
);
   initial begin
      if (DEPTH < 1 || DEPTH >= (1 << STK_W)) $error("stack depth out of range");
   end

   typedef struct packed {
      logic [DEPTH-1:0][PC_W-1:0] mem;
      logic [STK_W-1:0]           ptr;
      logic                       under;
      logic                       over;
   } rre_stk_type;

   rre_stk_type r;
   rre_stk_type next_r;

   always_comb begin
      next_r = r;
      if (i_push) begin
         if (r.ptr == STK_W'(DEPTH)) begin
            next_r.over = 1'b1;   // full: newest entry lost, flag sticks
         end else begin
            next_r.mem[r.ptr] = i_data;
            next_r.ptr        = r.ptr + 1'b1;
         end
      end else if (i_pop) begin
         if (r.ptr == '0) begin
            next_r.under = 1'b1;
         end else begin
            next_r.ptr = r.ptr - 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r <= '0;
      end else if (i_ce) begin
         r <= next_r;
      end
   end

   // empty stack yields zero so a stray return lands at the reset vector
   assign o_top   = (r.ptr == '0) ? '0 : r.mem[r.ptr - 1'b1];
   assign o_depth = r.ptr;
   assign o_under = r.under;
   assign o_over  = r.over;
endmodule

/* rtl/rre_exec.sv */
// return-from-subroutine and rotate-left-through-carry execution with Avalon-MM access
// ----------------------------------------
// rule summary
// ----------------------------------------
module rre_exec
   import rre_pkg::*;
#(
   parameter int STACK_DEPTH = 31,
   parameter int FILE_WORDS  = 4096
) (
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_ARST_N,
   input  wire logic        I_CE,
   input  wire logic [3:0]  I_AVS_ADDRESS,
   input  wire logic        I_AVS_READ,
   input  wire logic        I_AVS_WRITE,
   input  wire logic [31:0] I_AVS_WRITEDATA,
   output logic [31:0]      O_AVS_READDATA,
   output logic             O_AVS_WAITREQUEST,
   output logic [PC_W-1:0]  O_PC,
   output rre_ctx_type      O_CTX
);
   import rre_pkg::*;

   initial begin
      if (FILE_WORDS < 1 || FILE_WORDS > (1 << FADDR_W)) $error("file size out of range");
   end

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      rre_state_type              st;
      logic [PC_W-1:0]            pc;
      rre_ctx_type                ctx;
      rre_ctx_type                shadow;
      logic [INSN_W-1:0]          insn;
      logic [FADDR_W-1:0]         faddr;
      logic [FADDR_W-1:0]         rot_addr;
      logic [DATA_W-1:0]          rdata_f;
      logic [31:0]                rdata;
      logic                       wait_n;
   } rre_core_type;

   rre_core_type          r;
   rre_core_type          next_r;
   logic [DATA_W-1:0]     file_mem [FILE_WORDS];
   logic                  file_we;
   logic [FADDR_W-1:0]    file_wa;
   logic [DATA_W-1:0]     file_wd;
   logic [FADDR_W-1:0]    file_ra;

   logic                  stk_push;
   logic                  stk_pop;
   logic [PC_W-1:0]       stk_top;
   logic [STK_W-1:0]      stk_depth;
   logic                  stk_under;
   logic                  stk_over;

   logic                  is_ret;
   logic                  is_rot;
   logic [DATA_W-1:0]     rot_res;
   logic                  rot_carry;
   logic [FADDR_W-1:0]    eff_addr;
   logic [BANK_W-1:0]     eff_bank;
   logic [FADDR_W-1:0]    rd_sel;
   logic [DATA_W-1:0]     rd_word;

   rre_stack #(.DEPTH(STACK_DEPTH)) u_stack (
      .i_clk    (I_CLK_SYS),
      .i_arst_n (I_ARST_N),
      .i_ce     (I_CE),
      .i_push   (stk_push),
      .i_pop    (stk_pop),
      .i_data   (I_AVS_WRITEDATA[PC_W-1:0]),
      .o_top    (stk_top),
      .o_depth  (stk_depth),
      .o_under  (stk_under),
      .o_over   (stk_over)
   );

   // ----------------------------------------
   // decode of a bus-written opcode
   // ----------------------------------------
   always_comb begin
      is_ret = (I_AVS_WRITEDATA[INSN_W-1:1] == OPC_RETURN_HI);
      is_rot = (I_AVS_WRITEDATA[INSN_W-1:10] == OPC_ROTATE_LEFT_CARRY_OP_HI);
      if (!I_AVS_WRITEDATA[ROT_A_BIT]) begin
         eff_bank = (I_AVS_WRITEDATA[7:0] < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK;
      end else begin
         eff_bank = r.ctx.bank;
      end
      eff_addr = {eff_bank, I_AVS_WRITEDATA[7:0]};
   end

   // rotate uses the file word captured in the idle state
   always_comb begin
      rot_res   = {r.rdata_f[DATA_W-2:0], r.ctx.flags[FLG_C]};
      rot_carry = r.rdata_f[DATA_W-1];
   end

   // ----------------------------------------
   // bus slave and execution
   // ----------------------------------------
   always_comb begin
      next_r   = r;
      stk_push = 1'b0;
      stk_pop  = 1'b0;
      file_we  = 1'b0;
      file_wa  = r.rot_addr;
      file_wd  = rot_res;
      file_ra  = r.faddr;
      next_r.wait_n = 1'b0;
      case (r.st)
         RRE_IDLE: begin
            // capture the addressed file word for a rotate or a direct read
            next_r.rdata_f = rd_word;
            if (I_AVS_WRITE) begin
               next_r.st = RRE_RESP;
               if (I_AVS_ADDRESS == ADR_INSN) begin
                  next_r.insn = I_AVS_WRITEDATA[INSN_W-1:0];
                  if (is_ret) begin
                     stk_pop   = 1'b1;
                     next_r.pc = stk_top;
                     if (I_AVS_WRITEDATA[RET_S_BIT]) begin
                        next_r.ctx = r.shadow;
                     end
                  end else if (is_rot) begin
                     // one extra cycle to use the file word held in the rdata_f register
                     next_r.rot_addr = eff_addr;
                     next_r.st       = RRE_READ;
                  end
               end else if (I_AVS_ADDRESS == ADR_PC) begin
                  next_r.pc = I_AVS_WRITEDATA[PC_W-1:0];
               end else if (I_AVS_ADDRESS == ADR_WORK) begin
                  next_r.ctx.work = I_AVS_WRITEDATA[DATA_W-1:0];
               end else if (I_AVS_ADDRESS == ADR_FLAGS) begin
                  next_r.ctx.flags = I_AVS_WRITEDATA[DATA_W-1:0];
               end else if (I_AVS_ADDRESS == ADR_BANK) begin
                  next_r.ctx.bank = I_AVS_WRITEDATA[BANK_W-1:0];
               end else if (I_AVS_ADDRESS == ADR_SHW) begin
                  next_r.shadow.work = I_AVS_WRITEDATA[DATA_W-1:0];
               end else if (I_AVS_ADDRESS == ADR_SHF) begin
                  next_r.shadow.flags = I_AVS_WRITEDATA[DATA_W-1:0];
               end else if (I_AVS_ADDRESS == ADR_SHB) begin
                  next_r.shadow.bank = I_AVS_WRITEDATA[BANK_W-1:0];
               end else if (I_AVS_ADDRESS == ADR_PUSH) begin
                  stk_push = 1'b1;
               end else if (I_AVS_ADDRESS == ADR_FADDR) begin
                  next_r.faddr = I_AVS_WRITEDATA[FADDR_W-1:0];
               end else if (I_AVS_ADDRESS == ADR_FDATA) begin
                  file_we = 1'b1;
                  file_wa = r.faddr;
                  file_wd = I_AVS_WRITEDATA[DATA_W-1:0];
               end
            end else if (I_AVS_READ) begin
               next_r.st = RRE_READ;
            end
         end
         RRE_READ: begin
            next_r.st     = RRE_RESP;
            next_r.wait_n = 1'b1;
            if (I_AVS_WRITE) begin
               next_r.ctx.flags[FLG_C] = rot_carry;
               next_r.ctx.flags[FLG_N] = rot_res[DATA_W-1];
               next_r.ctx.flags[FLG_Z] = (rot_res == '0);
               if (r.insn[ROT_D_BIT]) begin
                  file_we = 1'b1;
               end else begin
                  next_r.ctx.work = rot_res;
               end
            end else begin
               if (I_AVS_ADDRESS == ADR_PC) begin
                  next_r.rdata = 32'(r.pc);
               end else if (I_AVS_ADDRESS == ADR_WORK) begin
                  next_r.rdata = 32'(r.ctx.work);
               end else if (I_AVS_ADDRESS == ADR_FLAGS) begin
                  next_r.rdata = 32'(r.ctx.flags);
               end else if (I_AVS_ADDRESS == ADR_BANK) begin
                  next_r.rdata = 32'(r.ctx.bank);
               end else if (I_AVS_ADDRESS == ADR_SHW) begin
                  next_r.rdata = 32'(r.shadow.work);
               end else if (I_AVS_ADDRESS == ADR_SHF) begin
                  next_r.rdata = 32'(r.shadow.flags);
               end else if (I_AVS_ADDRESS == ADR_SHB) begin
                  next_r.rdata = 32'(r.shadow.bank);
               end else if (I_AVS_ADDRESS == ADR_PUSH) begin
                  next_r.rdata = 32'(stk_top);
               end else if (I_AVS_ADDRESS == ADR_FADDR) begin
                  next_r.rdata = 32'(r.faddr);
               end else if (I_AVS_ADDRESS == ADR_FDATA) begin
                  next_r.rdata = 32'(r.rdata_f);
               end else if (I_AVS_ADDRESS == ADR_STAT) begin
                  next_r.rdata = 32'({stk_over, stk_under, stk_depth});
               end else begin
                  next_r.rdata = RD_UNMAPPED;
               end
            end
         end
         RRE_RESP: begin
            // released with waitrequest low; request drops next cycle
            next_r.st = RRE_IDLE;
         end
         default: begin
            next_r.st = RRE_IDLE;
         end
      endcase
      if (r.st == RRE_IDLE && I_AVS_WRITE) begin
         next_r.wait_n = !(I_AVS_ADDRESS == ADR_INSN && is_rot);
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         r <= '0;
      end else if (I_CE) begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // file register memory, registered write, combinational read
   // ----------------------------------------
   always_ff @(posedge I_CLK_SYS) begin
      if (I_CE) begin
         if (file_we) begin
            file_mem[file_wa] <= file_wd;
         end
      end
   end

   // read address: rotate target while idle on any bus write, else the direct pointer
   assign rd_sel  = (r.st == RRE_IDLE && I_AVS_WRITE) ? eff_addr : file_ra;
   assign rd_word = file_mem[rd_sel];

   assign O_AVS_READDATA    = r.rdata;
   assign O_AVS_WAITREQUEST = !r.wait_n;
   assign O_PC              = r.pc;
   assign O_CTX             = r.ctx;
endmodule

/* dv/rre_exec_properties.sv */
// checker: port-level properties of the return / rotate execution block
module rre_exec_properties (
   input wire logic                      I_CLK_SYS,
   input wire logic                      I_ARST_N,
   input wire logic                      I_CE,
   input wire logic [3:0]                I_AVS_ADDRESS,
   input wire logic                      I_AVS_READ,
   input wire logic                      I_AVS_WRITE,
   input wire logic [31:0]               I_AVS_WRITEDATA,
   input wire logic [31:0]               O_AVS_READDATA,
   input wire logic                      O_AVS_WAITREQUEST,
   input wire logic [rre_pkg::PC_W-1:0]  O_PC,
   input wire rre_pkg::rre_ctx_type      O_CTX
);
   import rre_pkg::*;
   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   logic        acc;
   logic        ret;
   logic        rot;
   rre_ctx_type shd;
   assign acc = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == ADR_INSN;
   assign ret = acc && I_AVS_WRITEDATA[15:1] == OPC_RETURN_HI;
   assign rot = acc && I_AVS_WRITEDATA[15:10] == OPC_ROTATE_LEFT_CARRY_OP_HI;
   // shadow copy follows accepted bus writes only, so no stack model is needed
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         shd <= '0;
      end else if (I_AVS_WRITE && !O_AVS_WAITREQUEST) begin
         if (I_AVS_ADDRESS == ADR_SHW) shd.work <= I_AVS_WRITEDATA[7:0];
         if (I_AVS_ADDRESS == ADR_SHF) shd.flags <= I_AVS_WRITEDATA[7:0];
         if (I_AVS_ADDRESS == ADR_SHB) shd.bank <= I_AVS_WRITEDATA[3:0];
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_ARST_N);
   a_ret_restore: assert property (ret && I_AVS_WRITEDATA[0] |-> O_CTX == shd)
      else $error("restoring return missed the shadow context");
   a_ret_keep: assert property (ret && !I_AVS_WRITEDATA[0] |-> O_CTX == $past(O_CTX))
      else $error("plain return altered the context");
   a_rot_carry_in: assert property (rot && !I_AVS_WRITEDATA[9] |->
      O_CTX.work[0] == $past(O_CTX.flags[FLG_C], 2))
      else $error("rotate result bit 0 is not the old carry");
   a_rot_nz_flags: assert property (rot && !I_AVS_WRITEDATA[9] |->
      O_CTX.flags[FLG_N] == O_CTX.work[7] && O_CTX.flags[FLG_Z] == (O_CTX.work == 8'h00))
      else $error("rotate negative or zero flag wrong");
   a_rot_keep_work: assert property (rot && I_AVS_WRITEDATA[9] |->
      O_CTX.work == $past(O_CTX.work, 2))
      else $error("rotate to file altered the work register");
   a_rot_keep_bank: assert property (rot |-> O_CTX.bank == $past(O_CTX.bank, 2))
      else $error("rotate altered the bank select");
   a_rot_keep_pc: assert property (rot |-> O_PC == $past(O_PC, 2))
      else $error("rotate moved the program counter");
   a_ack_one_cycle: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
      else $error("waitrequest low longer than one cycle");
endmodule

bind rre_exec rre_exec_properties u_rre_exec_properties (
   .I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .I_CE(I_CE), .I_AVS_ADDRESS(I_AVS_ADDRESS),
   .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
   .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_PC(O_PC),
   .O_CTX(O_CTX));

/* dv/rre_exec_tb_top.sv */
// testbench: random and corner-case checks of the return / rotate execution block
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module rre_exec_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rre_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic              clk, arst_n, ce, rd, wr, wreq, d, a;
   logic [3:0]        adr;
   logic [31:0]       wd, rdata, q;
   logic [PC_W-1:0]   pc;
   logic [PC_W-1:0]   stk [4];
   logic [7:0]        v, f, r;
   logic [3:0]        ab;
   logic [11:0]       fa, fb;
   rre_ctx_type       ctx, ex, sh;
   int                miscompares = 0;
   int                n_compared = 0;
   int                seed = 33450;
   rre_exec u_rre_exec (.I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_CE(ce), .I_AVS_ADDRESS(adr),
      .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdata),
      .O_AVS_WAITREQUEST(wreq), .O_PC(pc), .O_CTX(ctx));
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic av(input logic w, input logic [3:0] ad, input logic [31:0] dt,
                     output logic [31:0] qq);
      int n;
      @(posedge clk);
      adr <= ad;
      wd  <= dt;
      rd  <= !w;
      wr  <= w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      if (n >= 50) miscompares++;
      qq = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic wr_reg(input logic [3:0] ad, input logic [31:0] dt);
      logic [31:0] qq;
      av(1'b1, ad, dt, qq);
   endtask
   task automatic close_out;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // clock, watchdog, sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      close_out();
   end
   initial begin
      arst_n = 1'b0;
      ce = 1'b1;
      {rd, wr, adr, wd} = '0;
      repeat (20) @(posedge clk);
      `CHK(wreq, 1'b1)
      `CHK(pc, 21'h0)
      arst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         stk[i] = $random(seed);
         wr_reg(ADR_PUSH, stk[i]);
      end
      ex = $random(seed);
      sh = $random(seed);
      ex.flags[7:5] = 3'h0;
      sh.flags[7:5] = 3'h0;
      wr_reg(ADR_WORK, ex.work);
      wr_reg(ADR_FLAGS, ex.flags);
      wr_reg(ADR_BANK, ex.bank);
      wr_reg(ADR_SHW, sh.work);
      wr_reg(ADR_SHF, sh.flags);
      wr_reg(ADR_SHB, sh.bank);
      // last in first out, restore bit off then on
      for (int i = 3; i >= 0; i--) begin
         wr_reg(ADR_INSN, {OPC_RETURN_HI, !i[0]});
         if (!i[0]) ex = sh;
         `CHK(pc, stk[i])
         `CHK(ctx, ex)
      end
      // empty stack pops a zero
      wr_reg(ADR_INSN, {OPC_RETURN_HI, 1'b0});
      `CHK(pc, 21'h0)
      for (int i = 0; i < 24; i++) begin
         {v, f, d, a} = $random(seed);
         ex = $random(seed);
         ex.flags[7:5] = 3'h0;
         // corners: zero result with carry out, every d and a
         if (i < 4) begin
            v = 8'h80;
            ex.flags[FLG_C] = 1'b0;
            {a, d} = i[1:0];
         end
         ab = (f < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK;
         fa = a ? {ex.bank, f} : {ab, f};
         fb = a ? {ab, f} : {ex.bank, f};
         wr_reg(ADR_WORK, ex.work);
         wr_reg(ADR_FLAGS, ex.flags);
         wr_reg(ADR_BANK, ex.bank);
         // decoy in the other bank catches a wrong bank choice
         wr_reg(ADR_FADDR, fb);
         wr_reg(ADR_FDATA, ~v);
         wr_reg(ADR_FADDR, fa);
         wr_reg(ADR_FDATA, v);
         wr_reg(ADR_INSN, {OPC_ROTATE_LEFT_CARRY_OP_HI, d, a, f});
         r = {v[6:0], ex.flags[FLG_C]};
         if (!d) ex.work = r;
         ex.flags[FLG_C] = v[7];
         ex.flags[FLG_Z] = (r == 8'h00);
         ex.flags[FLG_N] = r[7];
         `CHK(ctx, ex)
         av(1'b0, ADR_FDATA, 32'h0, q);
         `CHK(q[7:0], d ? r : v)
      end
      av(1'b0, 4'hC, 32'h0, q);
      `CHK(q, RD_UNMAPPED)
      close_out();
   end
endmodule
